//--- verilog/epm_pkg.sv
// Shared constants and types for the external program memory strap port
package epm_pkg;
	localparam int        ADDR_W       = 16;
	localparam int        CLK_STRAP_LO = 0;
	localparam int        CLK_STRAP_HI = 1;
	localparam int        DRV_STRAP    = 2;
	localparam logic [1:0] FREQ_24      = 2'h0;
	localparam logic [1:0] FREQ_48      = 2'h3;
	localparam logic [1:0] STRAP_RST    = 2'h0;
	localparam logic       DRV_RST      = 1'h0;
	localparam logic       ROM_SEL_RST  = 1'h1;
	localparam logic       STROBE_IDLE  = 1'h1;
	localparam logic       FREQ48_RST   = 1'h0;
	localparam logic       FREQ_RSV_RST = 1'h0;
	localparam logic [15:0] ADDR_OE_RST = 16'hFFF8;
	localparam logic [1:0] PULLDOWN_RST = 2'h3;
	localparam logic [1:0] PULLDOWN_OFF = 2'h0;
	localparam logic [7:0] DATA_RST     = 8'h00;

	typedef enum logic [1:0] {
		EPM_IN_RESET,
		EPM_CAPTURE,
		EPM_RUN
	} epm_phase_e;

	typedef struct packed {
		epm_phase_e       phase;
		logic [1:0]       clk_strap;
		logic             drv_strap;
		logic             freq48;
		logic             freq_rsv;
		logic             rom_sel;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] addr_oe;
		logic [1:0]       pulldown_en;
		logic             wr_n;
		logic             rd_n;
		logic             ce_n;
		logic [7:0]       dout;
		logic             dout_oe;
		logic [7:0]       rdata;
	} epm_state_s;
endpackage

//--- verilog/epm_lowpwr.sv
// Low-power condition decode for the code memory port
module epm_lowpwr (
	input  wire logic idle_bit,
	input  wire logic wake_interrupt_line,
	input  wire logic sleep_bit,
	output logic      low_power
);
	// Idle set, wake line negated, sleep set
	assign low_power = idle_bit & ~wake_interrupt_line & sleep_bit;
endmodule

//--- verilog/epm_strap_port.sv
// External program memory port with reset-time straps
// Contract
// - In reset, low address pins read straps
// - Reset release latches straps, drops pull-downs
// - Strap 00 is 24 MHz, 11 is 48 MHz
// - Frequency strap pins at one float in low power
// - Strap zero pins drive like other addresses
// - Write strobe low signals write
// - Read strobe low signals read
// - Chip enable low outside low power
// - Chip enable high during reset
// - Third address strap selects clock driver
// - Data bus used only when internal select zero
module epm_strap_port (
	input  wire logic                       sys_clk,
	input  wire logic                       resetn,
	input  wire logic                       idle_bit,
	input  wire logic                       wake_interrupt_line,
	input  wire logic                       sleep_bit,
	input  wire logic [epm_pkg::ADDR_W-1:0] cpu_addr,
	input  wire logic                       cpu_rd,
	input  wire logic                       cpu_wr,
	input  wire logic [7:0]                 cpu_wdata,
	input  wire logic [2:0]                 strap_pins_in,
	input  wire logic                       rom_sel_pin_in,
	input  wire logic [7:0]                 code_mem_data_bus_in,
	output logic [epm_pkg::ADDR_W-1:0]      code_addr_out,
	output logic [epm_pkg::ADDR_W-1:0]      code_addr_oe,
	output logic [1:0]                      low_pin_pulldown_en,
	output logic                            code_mem_write_strobe_n,
	output logic                            code_mem_read_strobe_n,
	output logic                            code_mem_chip_enable_n,
	output logic [7:0]                      code_mem_data_bus_out,
	output logic                            code_mem_data_bus_oe,
	output logic [7:0]                      cpu_rdata,
	output logic [1:0]                      clk_freq_strap,
	output logic                            freq_is_48,
	output logic                            freq_reserved,
	output logic                            clock_driver_strap,
	output logic                            internal_code_select_bit
);
	// Registered state and its next value
	epm_pkg::epm_state_s s_q;
	epm_pkg::epm_state_s s_d;
	// Decoded low-power condition
	logic                low_power;
	// External bus usable for code transfers
	logic                ext_ok;
	// Write and read requests that reach the pins
	logic                wr_go;
	logic                rd_go;
	// Low address pin enables for this cycle
	logic [1:0]          low_oe;
	// Frequency strap levels on the low pins
	logic [1:0]          strap_now;

	// Strap pattern for 48 MHz operation
	function automatic logic freq_sel_48(
		input logic [1:0] strap
	);
		return strap == epm_pkg::FREQ_48;
	endfunction

	// Patterns 01 and 10 must not be used
	function automatic logic freq_sel_rsv(
		input logic [1:0] strap
	);
		return (strap != epm_pkg::FREQ_24) && (strap != epm_pkg::FREQ_48);
	endfunction

	// Strap one pins float in low power
	function automatic logic [1:0] low_pin_oe(
		input logic [1:0] strap,
		input logic       lp
	);
		logic [1:0] oe;
		oe = 2'h3;
		for (int i = 0; i < 2; i++)
		begin
			if (lp && strap[i])
			begin
				oe[i] = 1'h0;
			end
		end
		return oe;
	endfunction

	// Strobe level for a request, high when idle
	function automatic logic strobe_level(
		input logic go
	);
		return go ? !epm_pkg::STROBE_IDLE : epm_pkg::STROBE_IDLE;
	endfunction

	// Idle, wake and sleep combined
	epm_lowpwr u_lowpwr (
		.idle_bit            (idle_bit),
		.wake_interrupt_line (wake_interrupt_line),
		.sleep_bit           (sleep_bit),
		.low_power           (low_power)
	);

	// Requests only in run phase with external code
	assign ext_ok = (s_q.phase == epm_pkg::EPM_RUN) && !s_q.rom_sel;
	// Write wins when both requests stand
	assign wr_go = ext_ok && cpu_wr && !low_power;
	assign rd_go = ext_ok && cpu_rd && !cpu_wr && !low_power;
	// Pin enables of the two low address pins
	assign low_oe = low_pin_oe(s_q.clk_strap, low_power);
	// Clock frequency strap pins
	assign strap_now =
		strap_pins_in[epm_pkg::CLK_STRAP_HI:epm_pkg::CLK_STRAP_LO];

	// Next state
	always_comb
	begin
		s_d = s_q;
		case (s_q.phase)
			epm_pkg::EPM_IN_RESET:
			begin
				// First edge after release latches all straps
				s_d.clk_strap = strap_now;
				s_d.drv_strap = strap_pins_in[epm_pkg::DRV_STRAP];
				s_d.rom_sel = rom_sel_pin_in;
				// Frequency decodes kept in flops
				s_d.freq48 = freq_sel_48(strap_now);
				s_d.freq_rsv = freq_sel_rsv(strap_now);
				// Pull-downs off once straps are held
				s_d.pulldown_en = epm_pkg::PULLDOWN_OFF;
				s_d.phase = epm_pkg::EPM_RUN;
			end
			epm_pkg::EPM_CAPTURE:
			begin
				// Not entered; recovers to run
				s_d.phase = epm_pkg::EPM_RUN;
			end
			epm_pkg::EPM_RUN:
			begin
				// Straps stay put until the next reset
				s_d.phase = epm_pkg::EPM_RUN;
			end
			default:
			begin
				s_d.phase = epm_pkg::EPM_IN_RESET;
			end
		endcase
		// Pins follow the core only in run phase
		if (s_q.phase == epm_pkg::EPM_RUN)
		begin
			// Address and its drivers
			s_d.addr = cpu_addr;
			s_d.addr_oe = {epm_pkg::ADDR_W{1'h1}};
			s_d.addr_oe[1:0] = low_oe;
			// Chip enable and strobes
			s_d.ce_n = low_power;
			s_d.wr_n = strobe_level(wr_go);
			s_d.rd_n = strobe_level(rd_go);
			// Write data drives only during a write
			s_d.dout = cpu_wdata;
			s_d.dout_oe = wr_go;
			// Read data taken while the read strobe stands
			if (!s_q.rd_n)
			begin
				s_d.rdata = code_mem_data_bus_in;
			end
		end
	end

	// State register; reset puts pins 2:0 into strap duty
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_q.phase <= epm_pkg::EPM_IN_RESET;
			s_q.clk_strap <= epm_pkg::STRAP_RST;
			s_q.drv_strap <= epm_pkg::DRV_RST;
			s_q.freq48 <= epm_pkg::FREQ48_RST;
			s_q.freq_rsv <= epm_pkg::FREQ_RSV_RST;
			s_q.rom_sel <= epm_pkg::ROM_SEL_RST;
			s_q.addr <= '0;
			s_q.addr_oe <= epm_pkg::ADDR_OE_RST;
			s_q.pulldown_en <= epm_pkg::PULLDOWN_RST;
			s_q.wr_n <= epm_pkg::STROBE_IDLE;
			s_q.rd_n <= epm_pkg::STROBE_IDLE;
			s_q.ce_n <= epm_pkg::STROBE_IDLE;
			s_q.dout <= epm_pkg::DATA_RST;
			s_q.dout_oe <= 1'h0;
			s_q.rdata <= epm_pkg::DATA_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// Address pins and their drivers
	assign code_addr_out = s_q.addr;
	assign code_addr_oe = s_q.addr_oe;
	assign low_pin_pulldown_en = s_q.pulldown_en;

	// Memory strobes
	assign code_mem_write_strobe_n = s_q.wr_n;
	assign code_mem_read_strobe_n = s_q.rd_n;
	assign code_mem_chip_enable_n = s_q.ce_n;

	// Data bus and read data
	assign code_mem_data_bus_out = s_q.dout;
	assign code_mem_data_bus_oe = s_q.dout_oe;
	assign cpu_rdata = s_q.rdata;

	// Latched straps and their decodes
	assign clk_freq_strap = s_q.clk_strap;
	assign freq_is_48 = s_q.freq48;
	assign freq_reserved = s_q.freq_rsv;
	assign clock_driver_strap = s_q.drv_strap;
	assign internal_code_select_bit = s_q.rom_sel;
endmodule

//--- dv/epm_mem.sv
// Code memory model on the far side of the port
module epm_mem (
	input  wire logic       sys_clk, we_n, oe_n, ce_n,
	input  wire logic [7:0] addr, din,
	output logic      [7:0] dout
);
	logic [7:0] mem [256];
	logic [7:0] last;
	always_ff @(posedge sys_clk)
		if (!we_n && !ce_n) mem[addr] <= din;
	always_ff @(posedge sys_clk) last <= dout;
	// Released bus shows the inverse of the last value
	always_comb dout = (!oe_n && !ce_n) ? mem[addr] : ~last;
endmodule

//--- dv/epm_asserts.sv
// Checker for the strap port
module epm_chk (
	input wire logic        sys_clk, resetn, idle_bit, sleep_bit,
	input wire logic        wake_interrupt_line, cpu_rd, cpu_wr,
	input wire logic        rom_sel_pin_in, freq_is_48, freq_reserved,
	input wire logic [2:0]  strap_pins_in,
	input wire logic [15:0] code_addr_oe,
	input wire logic [1:0]  low_pin_pulldown_en, clk_freq_strap,
	input wire logic        code_mem_write_strobe_n, code_mem_read_strobe_n,
	input wire logic        code_mem_chip_enable_n, clock_driver_strap,
	input wire logic        internal_code_select_bit
);
	logic [1:0] up_q;
	wire logic  lp = idle_bit & ~wake_interrupt_line & sleep_bit;
	wire logic  run = up_q == 2'h3;
	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn) up_q <= 2'h0;
		else if (!run) up_q <= up_q + 2'h1;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	AST_RST: assert property ($rose(resetn) |-> code_mem_chip_enable_n
		&& low_pin_pulldown_en == 2'h3 && code_addr_oe[2:0] == 3'h0) else $error("reset pins");
	AST_LATCH: assert property ($rose(resetn) |=>
		$past(strap_pins_in) == {clock_driver_strap, clk_freq_strap}
		&& internal_code_select_bit == $past(rom_sel_pin_in)
		&& low_pin_pulldown_en == 2'h0) else $error("strap latch");
	AST_HOLD: assert property (run |-> $stable(clk_freq_strap)
		&& $stable(internal_code_select_bit)) else $error("strap moved");
	AST_FREQ: assert property (freq_is_48 == (clk_freq_strap == 2'h3)
		&& freq_reserved == ^clk_freq_strap) else $error("freq decode");
	AST_LP: assert property (run |-> code_addr_oe[1:0] ==
		($past(lp) ? ~clk_freq_strap : 2'h3)) else $error("low pin oe");
	AST_CE: assert property (run |-> code_mem_chip_enable_n == $past(lp))
		else $error("chip enable");
	AST_WR: assert property (run && cpu_wr && !lp && !internal_code_select_bit
		|=> !code_mem_write_strobe_n) else $error("write strobe");
	AST_RD: assert property (run && cpu_rd && !cpu_wr && !lp
		&& !internal_code_select_bit |=> !code_mem_read_strobe_n) else $error("read");
	AST_REF: assert property (run && (internal_code_select_bit || lp) |=>
		code_mem_read_strobe_n && code_mem_write_strobe_n) else $error("refuse");
endmodule
bind epm_strap_port epm_chk chk (.*);

//--- dv/tb.sv
// Testbench for the code memory strap port
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst_n = 0, idle = 0, wake = 0, slp = 0, rd = 0, wr = 0;
	logic        rom = 0, wr_n, rd_n, ce_n, mdoe, f48, frs, cds, ics;
	logic [15:0] a = 16'h0, ma, oe;
	logic [7:0]  wd = 8'h00, mdi, mdo, rdat;
	logic [2:0]  s = 3'h0;
	logic [1:0]  pd, fs;
	int          err_count = 0, comparisons = 0;
	always #12.5 clk = ~clk;
	epm_strap_port dut (.sys_clk(clk), .resetn(rst_n), .idle_bit(idle),
		.wake_interrupt_line(wake), .sleep_bit(slp), .cpu_addr(a), .cpu_rd(rd),
		.cpu_wr(wr), .cpu_wdata(wd), .strap_pins_in(s), .rom_sel_pin_in(rom),
		.code_mem_data_bus_in(mdi), .code_addr_out(ma), .code_addr_oe(oe),
		.low_pin_pulldown_en(pd), .code_mem_write_strobe_n(wr_n),
		.code_mem_read_strobe_n(rd_n), .code_mem_chip_enable_n(ce_n),
		.code_mem_data_bus_out(mdo), .code_mem_data_bus_oe(mdoe),
		.cpu_rdata(rdat), .clk_freq_strap(fs), .freq_is_48(f48),
		.freq_reserved(frs), .clock_driver_strap(cds),
		.internal_code_select_bit(ics));
	epm_mem mem (.sys_clk(clk), .we_n(wr_n), .oe_n(rd_n), .ce_n(ce_n),
		.addr(ma[7:0]), .din(mdo), .dout(mdi));
	task automatic chk(input logic [15:0] g, e);
		comparisons++;
		if (g !== e) begin err_count++; $display("Error %0t: %h not %h", $time, g, e); end
	endtask
	task automatic boot(input logic [2:0] st, input logic r);
		{rst_n, s, rom} = {1'b0, st, r};
		repeat (2) @(negedge clk);
		chk({ce_n, pd, oe[2:0]}, 16'h38);
		rst_n = 1;
		repeat (4) @(negedge clk);
		chk({f48, frs, cds, ics, pd, fs},
			{st[1:0] == 2'h3, ^st[1:0], st[2], r, 2'h0, st[1:0]});
		$display("boot %h end", st);
	endtask
	task automatic rw(input logic w, input logic [7:0] ad, d);
		{wr, rd, a, wd} = {w, !w, 8'h00, ad, d};
		@(negedge clk) {wr, rd} = 2'h0;
		chk({wr_n, rd_n, mdoe, ma[7:0]}, {!w, w, w, ad});
		if (w) chk(mdo, d);
		repeat (2) @(negedge clk);
		if (!w) chk(rdat, d);
		$display("rw %h end", ad);
	endtask
	task automatic lowp(input logic [1:0] st);
		{idle, slp} = 2'h3;
		repeat (2) @(negedge clk);
		chk({ce_n, oe[1:0]}, {1'b1, ~st});
		wake = 1;
		repeat (2) @(negedge clk);
		chk({ce_n, oe[1:0]}, 16'h3);
		{idle, slp, wake} = 3'h0;
		$display("lowp end");
	endtask
	task automatic refuse;
		rd = 1;
		@(negedge clk);
		@(negedge clk) rd = 0;
		chk({rd_n, wr_n}, 16'h3);
		$display("refuse end");
	endtask
	task automatic end_of_test;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		@(negedge clk);
		boot(3'h3, 0);
		rw(1, 8'h12, 8'hA5);
		rw(1, 8'h34, 8'h3C);
		rw(0, 8'h12, 8'hA5);
		rw(0, 8'h34, 8'h3C);
		lowp(2'h3);
		boot(3'h4, 0);
		lowp(2'h0);
		boot(3'h1, 1);
		refuse;
		boot(3'h6, 1);
		lowp(2'h2);
		end_of_test;
	end
endmodule
